// file: flags_pkg.sv
// Purpose: constants and carriers for the radio status flag bank.
// Assumes: 8-bit register port, 100 MHz clk_sys.
// Notes: offsets are the printed register addresses.
package flags_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_EVENT_FLAGS1 = 8'h3e;
	localparam logic [7:0] ADDR_EVENT_FLAGS2 = 8'h3f;
	localparam logic [7:0] ADDR_SUPPLY_CTRL = 8'h3d;
	localparam logic [7:0] ADDR_QUEUE_CTRL = 8'h50;
	localparam logic [7:0] ADDR_STATUS_MISC = 8'h51;
	localparam logic [7:0] SUPPLY_CTRL_RESET = 8'h02;
	localparam logic [7:0] QUEUE_CTRL_RESET = 8'h0f;

	// ==========================================================
	// Field positions, first flag register
	localparam int F1_MODE_SETTLED = 7;
	localparam int F1_RECEIVE_SETTLED = 6;
	localparam int F1_TRANSMIT_SETTLED = 5;
	localparam int F1_SYNTH_LOCKED = 4;
	localparam int F1_SIGNAL_STRENGTH = 3;
	localparam int F1_TIMEOUT = 2;
	localparam int F1_LEAD_IN_FOUND = 1;
	localparam int F1_FRAME_MARKER = 0;

	// ==========================================================
	// Field positions, second flag register
	localparam int F2_QUEUE_FULL = 7;
	localparam int F2_QUEUE_EMPTY = 6;
	localparam int F2_QUEUE_ABOVE = 5;
	localparam int F2_QUEUE_OVERFLOW = 4;
	localparam int F2_FRAME_SENT = 3;
	localparam int F2_PAYLOAD_AVAILABLE = 2;
	localparam int F2_CHECK_PASSED = 1;
	localparam int F2_SUPPLY_LOW = 0;

	// ==========================================================
	// Control fields
	localparam int SUPPLY_MONITOR_ON_BIT = 3;
	localparam int QUEUE_LIMIT_MSB = 6;
	localparam int QUEUE_MODE_PACKET_BIT = 7;
	localparam logic [6:0] QUEUE_CAPACITY = 7'h42;

	// ==========================================================
	// Operating modes
	typedef enum logic [2:0] {
		MODE_SLEEP = 3'b000,
		MODE_STANDBY = 3'b001,
		MODE_SYNTH = 3'b010,
		MODE_TRANSMIT = 3'b011,
		MODE_RECEIVE = 3'b100
	} op_mode_t;

	// Condition inputs from the radio core, sampled through synchronisers.
	typedef struct packed {
		logic osc_running;
		logic pll_locked;
		logic sampling_started;
		logic rx_tuning_done;
		logic pa_ramp_done;
		logic strength_over_limit;
		logic timeout_hit;
		logic lead_in_seen;
		logic marker_seen;
		logic packet_done;
		logic last_byte_in;
		logic check_good;
		logic overrun_hit;
		logic below_supply_limit;
	} radio_events_t;

	localparam int EVENT_WIDTH = 14;

	// Register port request.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage : flags_pkg

// file: radio_fsk_status_flags.sv
// Purpose: two status/event flag registers of an FSK radio transceiver.
// Assumes: radio core conditions arrive from another clock domain; register port on clk_sys.
// Notes: the queue byte count arrives from FIFO logic on clk_sys.
// Operation
// RULE1: mode_settled sets once requested mode is ready.
// RULE2: mode_settled clears on every operating mode change.
// RULE3: receive_settled sets in receive after tuning; clears leaving receive.
// RULE4: transmit_settled sets in transmit after amplifier ramp; clears leaving transmit.
// RULE5: synth_locked follows PLL lock in synth, receive, transmit modes.
// RULE6: signal strength flag sets above limit in receive; clears leaving or writing one.
// RULE7: timeout flag sets on timeout; clears leaving receive or queue emptied.
// RULE8: lead_in_found sets on valid preamble; host writes one to clear.
// RULE9: frame_marker_match sets on sync/address; clears leaving receive or queue emptied.
// RULE10: frame_marker_match read-only in packet mode, write-one-clear in continuous.
// RULE11: queue_full high exactly while queue holds 66 bytes.
// RULE12: queue_empty high while queue holds no byte.
// RULE13: queue_above_limit high while count strictly exceeds queue_limit.
// RULE14: queue_overflow sets on overrun except in sleep mode.
// RULE15: writing one to queue_overflow flushes queue and its flags.
// RULE16: frame_sent sets after packet sent in transmit; clears leaving transmit.
// RULE17: payload_available sets after last byte, gated by check; clears when empty.
// RULE18: check_passed sets on good payload check in receive; clears when empty.
// RULE19: supply_low sets below threshold; stays until host writes one.
// RULE20: supply comparison runs only while supply_monitor_on; trim selects eight levels.
// RULE21: zero writes and read-only bit writes leave flags unchanged.
module radio_fsk_status_flags
	import flags_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Register port
	input wire reg_req_t req,
	output logic [7:0] rdata,
	// Mode and packet configuration from the mode controller
	input wire op_mode_t op_mode,
	input wire logic check_enabled,
	input wire logic keep_on_check_fail,
	// Radio core conditions (asynchronous)
	input wire radio_events_t events_async,
	// Queue occupancy (same clock)
	input wire logic [6:0] queue_count,
	// Status out
	output logic queue_flush,
	output logic [2:0] supply_limit_trim,
	output logic supply_monitor_on
);

	// ==========================================================
	// Input synchronisers
	radio_events_t ev_meta_reg;
	radio_events_t ev_reg;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ev_meta_reg <= '0;
			ev_reg <= '0;
		end else begin
			ev_meta_reg <= events_async;
			ev_reg <= ev_meta_reg;
		end
	end

	// ==========================================================
	// Mode tracking and write decode
	op_mode_t mode_prev_reg;
	logic mode_changed;
	logic in_rx;
	logic in_tx;
	logic left_rx;
	logic left_tx;
	logic wr1;
	logic wr2;
	logic [7:0] supply_ctrl_reg;
	logic [7:0] queue_ctrl_reg;
	logic queue_is_empty;
	logic packet_mode;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode_prev_reg <= MODE_SLEEP;
		end else begin
			mode_prev_reg <= op_mode;
		end
	end

	assign mode_changed = (op_mode != mode_prev_reg);
	assign in_rx = (op_mode == MODE_RECEIVE);
	assign in_tx = (op_mode == MODE_TRANSMIT);
	assign left_rx = (mode_prev_reg == MODE_RECEIVE) && !in_rx;
	assign left_tx = (mode_prev_reg == MODE_TRANSMIT) && !in_tx;
	// RULE21 flag write decode
	assign wr1 = req.wr && (req.addr == ADDR_EVENT_FLAGS1);
	assign wr2 = req.wr && (req.addr == ADDR_EVENT_FLAGS2);
	assign queue_is_empty = (queue_count == 7'h00);
	assign packet_mode = queue_ctrl_reg[QUEUE_MODE_PACKET_BIT];

	// ==========================================================
	// Control registers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			supply_ctrl_reg <= SUPPLY_CTRL_RESET;
			queue_ctrl_reg <= QUEUE_CTRL_RESET;
		end else begin
			if (req.wr && req.addr == ADDR_SUPPLY_CTRL) begin
				supply_ctrl_reg <= {4'h0, req.wdata[3:0]};
			end
			if (req.wr && req.addr == ADDR_QUEUE_CTRL) begin
				queue_ctrl_reg <= req.wdata;
			end
		end
	end

	// ==========================================================
	// First flag register
	logic mode_settled_reg;
	logic receive_settled_reg;
	logic transmit_settled_reg;
	logic synth_locked_reg;
	logic strength_reg;
	logic timeout_reg;
	logic lead_in_found_reg;
	logic frame_marker_match_reg;
	logic mode_ready_cond;

	// RULE1 mode ready conditions
	always_comb begin
		case (op_mode)
			MODE_SLEEP: mode_ready_cond = 1'b1;
			MODE_STANDBY: mode_ready_cond = ev_reg.osc_running;
			MODE_SYNTH: mode_ready_cond = ev_reg.pll_locked;
			MODE_RECEIVE: mode_ready_cond = ev_reg.sampling_started;
			MODE_TRANSMIT: mode_ready_cond = ev_reg.pa_ramp_done;
			default: mode_ready_cond = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode_settled_reg <= 1'b0;
		// RULE2 clear on change
		end else if (mode_changed) begin
			mode_settled_reg <= 1'b0;
		end else if (mode_ready_cond) begin
			mode_settled_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			receive_settled_reg <= 1'b0;
			transmit_settled_reg <= 1'b0;
			synth_locked_reg <= 1'b0;
		end else begin
			// RULE3 receive settled
			receive_settled_reg <= in_rx && (receive_settled_reg || ev_reg.rx_tuning_done);
			// RULE4 transmit settled
			transmit_settled_reg <= in_tx && (transmit_settled_reg || ev_reg.pa_ramp_done);
			// RULE5 lock follows PLL
			synth_locked_reg <= ev_reg.pll_locked &&
				(op_mode == MODE_SYNTH || in_rx || in_tx);
		end
	end

	// Set beats a same-cycle clear for every sticky flag except mode_settled, receive_settled, transmit_settled and frame_sent, where the clear wins.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			strength_reg <= 1'b0;
			timeout_reg <= 1'b0;
			lead_in_found_reg <= 1'b0;
			frame_marker_match_reg <= 1'b0;
		end else begin
			// RULE6 strength flag
			if (in_rx && ev_reg.strength_over_limit) begin
				strength_reg <= 1'b1;
			end else if (!in_rx || (wr1 && req.wdata[F1_SIGNAL_STRENGTH])) begin
				strength_reg <= 1'b0;
			end
			// RULE7 timeout flag
			if (ev_reg.timeout_hit) begin
				timeout_reg <= 1'b1;
			end else if (left_rx || queue_is_empty) begin
				timeout_reg <= 1'b0;
			end
			// RULE8 preamble flag
			if (ev_reg.lead_in_seen) begin
				lead_in_found_reg <= 1'b1;
			end else if (wr1 && req.wdata[F1_LEAD_IN_FOUND]) begin
				lead_in_found_reg <= 1'b0;
			end
			// RULE9 RULE10 marker flag
			if (ev_reg.marker_seen) begin
				frame_marker_match_reg <= 1'b1;
			end else if (left_rx || queue_is_empty ||
				(!packet_mode && wr1 && req.wdata[F1_FRAME_MARKER])) begin
				frame_marker_match_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Second flag register
	logic queue_full_reg;
	logic queue_empty_reg;
	logic queue_above_reg;
	logic queue_overflow_reg;
	logic frame_sent_reg;
	logic payload_available_reg;
	logic check_passed_reg;
	logic supply_low_reg;
	logic flush_req;
	logic payload_ok;

	// RULE15 flush on write one
	assign flush_req = wr2 && req.wdata[F2_QUEUE_OVERFLOW];
	// RULE17 check gating
	assign payload_ok = !check_enabled || keep_on_check_fail || ev_reg.check_good;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			queue_full_reg <= 1'b0;
			queue_empty_reg <= 1'b1;
			queue_above_reg <= 1'b0;
			queue_flush <= 1'b0;
		end else begin
			// RULE11 full at capacity
			queue_full_reg <= (queue_count == QUEUE_CAPACITY);
			// RULE12 empty level
			queue_empty_reg <= queue_is_empty;
			// RULE13 strict compare
			queue_above_reg <= (queue_count > queue_ctrl_reg[QUEUE_LIMIT_MSB:0]);
			queue_flush <= flush_req;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			queue_overflow_reg <= 1'b0;
			frame_sent_reg <= 1'b0;
			payload_available_reg <= 1'b0;
			check_passed_reg <= 1'b0;
		end else begin
			// RULE14 RULE15 overflow flag
			if (ev_reg.overrun_hit && op_mode != MODE_SLEEP) begin
				queue_overflow_reg <= 1'b1;
			end else if (flush_req) begin
				queue_overflow_reg <= 1'b0;
			end
			// RULE16 frame sent
			frame_sent_reg <= in_tx && (frame_sent_reg || ev_reg.packet_done);
			// RULE17 payload flag
			if (in_rx && ev_reg.last_byte_in && payload_ok) begin
				payload_available_reg <= 1'b1;
			end else if (queue_is_empty || flush_req) begin
				payload_available_reg <= 1'b0;
			end
			// RULE18 check flag
			if (in_rx && ev_reg.last_byte_in && ev_reg.check_good) begin
				check_passed_reg <= 1'b1;
			end else if (queue_is_empty || flush_req) begin
				check_passed_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			supply_low_reg <= 1'b0;
		// RULE19 RULE20 supply flag
		end else if (supply_ctrl_reg[SUPPLY_MONITOR_ON_BIT] && ev_reg.below_supply_limit) begin
			supply_low_reg <= 1'b1;
		end else if (wr2 && req.wdata[F2_SUPPLY_LOW]) begin
			supply_low_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Read port and outputs
	logic [7:0] flags1;
	logic [7:0] flags2;
	assign flags1 = {mode_settled_reg, receive_settled_reg, transmit_settled_reg, synth_locked_reg,
		strength_reg, timeout_reg, lead_in_found_reg, frame_marker_match_reg};
	assign flags2 = {queue_full_reg, queue_empty_reg, queue_above_reg, queue_overflow_reg,
		frame_sent_reg, payload_available_reg, check_passed_reg, supply_low_reg};

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata <= 8'h00;
			supply_limit_trim <= SUPPLY_CTRL_RESET[2:0];
			supply_monitor_on <= 1'b0;
		end else begin
			supply_limit_trim <= supply_ctrl_reg[2:0];
			supply_monitor_on <= supply_ctrl_reg[SUPPLY_MONITOR_ON_BIT];
			if (req.rd) begin
				case (req.addr)
					ADDR_EVENT_FLAGS1: rdata <= flags1;
					ADDR_EVENT_FLAGS2: rdata <= flags2;
					ADDR_SUPPLY_CTRL: rdata <= supply_ctrl_reg;
					ADDR_QUEUE_CTRL: rdata <= queue_ctrl_reg;
					ADDR_STATUS_MISC: rdata <= {5'h00, op_mode};
					default: rdata <= 8'h00;
				endcase
			end else begin
				rdata <= 8'h00;
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	mode_clear_a: assert property (mode_changed |=> !mode_settled_reg) else $error("mode flag kept"); // RULE2
	rx_settled_a: assert property (receive_settled_reg |-> $past(in_rx)) else $error("rx flag outside rx"); // RULE3
	tx_settled_a: assert property (transmit_settled_reg |-> $past(in_tx)) else $error("tx flag outside tx"); // RULE4
	lock_follow_a: assert property (synth_locked_reg |-> $past(ev_reg.pll_locked)) else $error("lock wrong"); // RULE5
	full_level_a: assert property (queue_full_reg == ($past(queue_count) == QUEUE_CAPACITY)) else $error("full wrong"); // RULE11
	empty_level_a: assert property (queue_empty_reg == $past(queue_is_empty)) else $error("empty wrong"); // RULE12
	sleep_overrun_a: assert property ((op_mode == MODE_SLEEP && !queue_overflow_reg && !mode_changed)
		|=> !queue_overflow_reg) else $error("overrun in sleep"); // RULE14
	supply_hold_a: assert property ((supply_low_reg && !(wr2 && req.wdata[F2_SUPPLY_LOW])) |=> supply_low_reg)
		else $error("supply flag lost"); // RULE19
	flush_pulse_a: assert property (flush_req |=> queue_flush ##1 (queue_flush == $past(flush_req))) // RULE15
		else $error("flush pulse wrong");

	rx_seen_c: cover property (in_rx ##1 receive_settled_reg);
	sent_c: cover property (frame_sent_reg);
	overflow_c: cover property (queue_overflow_reg ##1 flush_req);
	payload_c: cover property (payload_available_reg && check_passed_reg);
	supply_c: cover property (supply_low_reg ##1 !supply_low_reg);

	// ==========================================================
	// Flag checks
	// Each flag may change only through its own set and clear terms.
	mode_ready_a: assert property ((!mode_changed && mode_ready_cond) |=> mode_settled_reg) // RULE1
		else $error("mode flag not set");
	rx_leave_a: assert property (left_rx |=> !receive_settled_reg) // RULE3
		else $error("rx flag kept after receive");
	tx_leave_a: assert property (left_tx |=> !transmit_settled_reg && !frame_sent_reg) // RULE4
		else $error("tx flags kept after transmit");
	lock_idle_a: assert property ((op_mode == MODE_STANDBY || op_mode == MODE_SLEEP) |=> !synth_locked_reg) // RULE5
		else $error("lock shown outside synth modes");
	strength_rx_a: assert property (strength_reg |-> $past(in_rx)) // RULE6
		else $error("strength flag outside receive");
	strength_clear_a: assert property ((wr1 && req.wdata[F1_SIGNAL_STRENGTH] && !ev_reg.strength_over_limit) // RULE6
		|=> !strength_reg) else $error("strength flag not cleared");
	timeout_clear_a: assert property (((left_rx || queue_is_empty) && !ev_reg.timeout_hit) |=> !timeout_reg) // RULE7
		else $error("timeout flag not cleared");
	lead_in_clear_a: assert property ((wr1 && req.wdata[F1_LEAD_IN_FOUND] && !ev_reg.lead_in_seen) // RULE8
		|=> !lead_in_found_reg) else $error("lead-in flag not cleared");
	lead_in_hold_a: assert property ((lead_in_found_reg && !(wr1 && req.wdata[F1_LEAD_IN_FOUND])) // RULE8
		|=> lead_in_found_reg) else $error("lead-in flag lost");
	marker_clear_a: assert property (((left_rx || queue_is_empty) && !ev_reg.marker_seen) // RULE9
		|=> !frame_marker_match_reg) else $error("marker flag not cleared");
	marker_packet_a: assert property ((packet_mode && frame_marker_match_reg && !left_rx && !queue_is_empty) // RULE10
		|=> frame_marker_match_reg) else $error("marker flag cleared in packet mode");
	queue_excl_a: assert property (!(queue_full_reg && queue_empty_reg)) // RULE11
		else $error("queue full and empty together");
	above_level_a: assert property (queue_above_reg == ($past(queue_count) > $past(queue_ctrl_reg[QUEUE_LIMIT_MSB:0]))) // RULE13
		else $error("above-limit flag wrong");
	flush_clear_a: assert property ((flush_req && !ev_reg.overrun_hit) |=> !queue_overflow_reg) // RULE15
		else $error("overflow flag kept after flush");
	sent_tx_a: assert property (frame_sent_reg |-> $past(in_tx)) // RULE16
		else $error("sent flag outside transmit");
	payload_gate_a: assert property ($rose(payload_available_reg) // RULE17
		|-> $past(in_rx) && $past(ev_reg.last_byte_in) && $past(payload_ok)) else $error("bad payload flag");
	payload_empty_a: assert property ((queue_is_empty && !(in_rx && ev_reg.last_byte_in)) // RULE17
		|=> !payload_available_reg) else $error("payload flag kept when empty");
	check_rx_a: assert property ($rose(check_passed_reg) // RULE18
		|-> $past(in_rx) && $past(ev_reg.last_byte_in) && $past(ev_reg.check_good)) else $error("bad check flag");
	supply_gate_a: assert property ($rose(supply_low_reg) |-> $past(supply_ctrl_reg[SUPPLY_MONITOR_ON_BIT])) // RULE20
		else $error("supply flag with monitor off");

endmodule : radio_fsk_status_flags

// file: radio_fsk_status_flags_bench.sv
// Purpose: self-checking bench for the radio status flag bank.
// Assumes: read data stands one cycle after the read strobe.
// Notes: radio conditions are held for several cycles to cross the synchronisers.
module radio_fsk_status_flags_bench
	import flags_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ========
	// Signals and design
	logic clk_sys;
	logic resetn;
	reg_req_t req;
	logic [7:0] rdata;
	op_mode_t op_mode;
	logic check_enabled;
	logic keep_on_check_fail;
	radio_events_t events_async;
	logic [6:0] queue_count;
	logic queue_flush;
	logic [2:0] supply_limit_trim;
	logic supply_monitor_on;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;

	radio_fsk_status_flags radio_fsk_status_flags_i (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.req(req),
		.rdata(rdata),
		.op_mode(op_mode),
		.check_enabled(check_enabled),
		.keep_on_check_fail(keep_on_check_fail),
		.events_async(events_async),
		.queue_count(queue_count),
		.queue_flush(queue_flush),
		.supply_limit_trim(supply_limit_trim),
		.supply_monitor_on(supply_monitor_on)
	);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// A hung run is counted as a mismatch and closed.
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	// ========
	// Shared tasks
	task automatic report_and_stop();
		if (failures == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] expected);
		cmp_count++;
		if (seen !== expected) begin
			failures++;
			$display("Error %s expected %h seen %h", name, expected, seen);
		end
	endtask : chk

	task automatic settle();
		repeat (6) @(posedge clk_sys);
	endtask : settle

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		req.wr <= 1'b0;
	endtask : wr

	task automatic chk_reg(input logic [7:0] a, input logic [7:0] expected, input string name);
		@(posedge clk_sys);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		req.rd <= 1'b0;
		@(posedge clk_sys);
		chk(name, rdata, expected);
	endtask : chk_reg

	// ========
	// Scenarios
	task automatic mode_test();
		events_async.osc_running <= 1'b1;
		settle();
		chk_reg(ADDR_EVENT_FLAGS1, 8'h80, "standby ready");
		op_mode <= MODE_SYNTH;
		settle();
		chk_reg(ADDR_EVENT_FLAGS1, 8'h00, "mode change");
		events_async.pll_locked <= 1'b1;
		settle();
		chk_reg(ADDR_EVENT_FLAGS1, 8'h90, "synth locked");
		op_mode <= MODE_TRANSMIT;
		settle();
		chk_reg(ADDR_EVENT_FLAGS1, 8'h10, "transmit pending");
		events_async.pa_ramp_done <= 1'b1;
		events_async.packet_done <= 1'b1;
		settle();
		chk_reg(ADDR_EVENT_FLAGS1, 8'hb0, "transmit ready");
		chk_reg(ADDR_EVENT_FLAGS2, 8'h48, "frame sent");
		events_async.pll_locked <= 1'b0;
		settle();
		chk_reg(ADDR_EVENT_FLAGS1, 8'ha0, "lock lost");
		// Drops amplifier ramp through packet done.
		events_async[9:4] <= 6'h00;
		op_mode <= MODE_STANDBY;
		settle();
		chk_reg(ADDR_EVENT_FLAGS1, 8'h80, "transmit left");
		chk_reg(ADDR_EVENT_FLAGS2, 8'h40, "sent cleared");
	endtask : mode_test

	task automatic receive_test();
		op_mode <= MODE_RECEIVE;
		queue_count <= 7'h05;
		events_async.pll_locked <= 1'b1;
		events_async.sampling_started <= 1'b1;
		events_async.rx_tuning_done <= 1'b1;
		settle();
		chk_reg(ADDR_EVENT_FLAGS1, 8'hd0, "receive settled");
		// Pulses strength, timeout, lead-in and marker conditions.
		events_async[8:5] <= 4'hf;
		settle();
		events_async[8:5] <= 4'h0;
		settle();
		chk_reg(ADDR_EVENT_FLAGS1, 8'hdf, "receive events");
		wr(ADDR_EVENT_FLAGS1, 8'h00);
		wr(ADDR_EVENT_FLAGS1, 8'hf4);
		chk_reg(ADDR_EVENT_FLAGS1, 8'hdf, "ignored writes");
		wr(ADDR_QUEUE_CTRL, 8'h8f);
		wr(ADDR_EVENT_FLAGS1, 8'h01);
		chk_reg(ADDR_EVENT_FLAGS1, 8'hdf, "marker packet mode");
		wr(ADDR_QUEUE_CTRL, QUEUE_CTRL_RESET);
		wr(ADDR_EVENT_FLAGS1, 8'h0b);
		chk_reg(ADDR_EVENT_FLAGS1, 8'hd4, "write one clear");
		queue_count <= 7'h00;
		settle();
		chk_reg(ADDR_EVENT_FLAGS1, 8'hd0, "timeout emptied");
		events_async.strength_over_limit <= 1'b1;
		events_async.timeout_hit <= 1'b1;
		events_async.marker_seen <= 1'b1;
		queue_count <= 7'h05;
		settle();
		chk_reg(ADDR_EVENT_FLAGS1, 8'hdd, "strength again");
		events_async[12:5] <= 8'h00;
		settle();
		op_mode <= MODE_STANDBY;
		settle();
		chk_reg(ADDR_EVENT_FLAGS1, 8'h80, "receive left");
	endtask : receive_test

	task automatic queue_levels();
		logic [6:0] counts [6] = '{7'h00, 7'h01, 7'h0f, 7'h10, 7'h41, 7'h42};
		logic [7:0] exp;
		foreach (counts[i]) begin
			queue_count <= counts[i];
			settle();
			exp = {counts[i] == QUEUE_CAPACITY, counts[i] == 7'h00, counts[i] > QUEUE_CTRL_RESET[6:0], 5'h00};
			chk_reg(ADDR_EVENT_FLAGS2, exp, "queue levels");
		end
	endtask : queue_levels

	task automatic payload_test();
		op_mode <= MODE_RECEIVE;
		queue_count <= 7'h0a;
		check_enabled <= 1'b1;
		events_async.last_byte_in <= 1'b1;
		settle();
		chk_reg(ADDR_EVENT_FLAGS2, 8'h00, "payload bad check");
		keep_on_check_fail <= 1'b1;
		settle();
		chk_reg(ADDR_EVENT_FLAGS2, 8'h04, "payload kept on fail");
		keep_on_check_fail <= 1'b0;
		events_async.check_good <= 1'b1;
		settle();
		chk_reg(ADDR_EVENT_FLAGS2, 8'h06, "payload good");
		events_async.overrun_hit <= 1'b1;
		settle();
		events_async <= '0;
		settle();
		chk_reg(ADDR_EVENT_FLAGS2, 8'h16, "overflow set");
		wr(ADDR_EVENT_FLAGS2, 8'h10);
		@(posedge clk_sys);
		chk("flush pulse", {7'h00, queue_flush}, 8'h01);
		chk_reg(ADDR_EVENT_FLAGS2, 8'h00, "after flush");
		events_async.last_byte_in <= 1'b1;
		events_async.check_good <= 1'b1;
		settle();
		events_async <= '0;
		queue_count <= 7'h00;
		settle();
		chk_reg(ADDR_EVENT_FLAGS2, 8'h40, "payload emptied");
		op_mode <= MODE_SLEEP;
		events_async.overrun_hit <= 1'b1;
		settle();
		events_async <= '0;
		settle();
		chk_reg(ADDR_EVENT_FLAGS2, 8'h40, "overrun in sleep");
	endtask : payload_test

	task automatic supply_test();
		events_async.below_supply_limit <= 1'b1;
		settle();
		chk_reg(ADDR_EVENT_FLAGS2, 8'h40, "monitor off");
		wr(ADDR_SUPPLY_CTRL, 8'h0d);
		repeat (2) @(posedge clk_sys);
		chk("supply outputs", {4'h0, supply_monitor_on, supply_limit_trim}, 8'h0d);
		settle();
		events_async <= '0;
		settle();
		chk_reg(ADDR_EVENT_FLAGS2, 8'h41, "supply low held");
		wr(ADDR_EVENT_FLAGS2, 8'h00);
		chk_reg(ADDR_EVENT_FLAGS2, 8'h41, "zero write");
		wr(ADDR_EVENT_FLAGS2, 8'h01);
		chk_reg(ADDR_EVENT_FLAGS2, 8'h40, "supply cleared");
	endtask : supply_test

	// ========
	// Main sequence
	initial begin
		resetn = 1'b0;
		req = '0;
		op_mode = MODE_STANDBY;
		check_enabled = 1'b0;
		keep_on_check_fail = 1'b0;
		events_async = '0;
		queue_count = 7'h00;
		repeat (12) @(posedge clk_sys);
		chk("reset outputs", {3'h0, queue_flush, supply_monitor_on, supply_limit_trim}, 8'h02);
		resetn <= 1'b1;
		settle();
		chk_reg(ADDR_EVENT_FLAGS1, 8'h00, "flags1 reset");
		chk_reg(ADDR_EVENT_FLAGS2, 8'h40, "flags2 reset");
		chk_reg(ADDR_SUPPLY_CTRL, SUPPLY_CTRL_RESET, "supply reset");
		chk_reg(ADDR_QUEUE_CTRL, QUEUE_CTRL_RESET, "queue ctrl reset");
		chk_reg(8'h10, 8'h00, "unmapped read");
		chk_reg(ADDR_STATUS_MISC, {5'h00, MODE_STANDBY}, "mode readback");
		mode_test();
		receive_test();
		queue_levels();
		payload_test();
		supply_test();
		report_and_stop();
	end

endmodule : radio_fsk_status_flags_bench
